// >>> hw/rtvm_map.vh
// Address map and vector number constants of the reset and vector mapper
`ifndef RTVM_MAP_VH
`define RTVM_MAP_VH

// ----------------------------------------
// Program memory layout
// ----------------------------------------
`define RTVM_RESET_ADDR      24'h000000
`define RTVM_TRAP_BASE       24'h000004
`define RTVM_IRQ_BASE        24'h000014
`define RTVM_ALT_OFFSET      24'h000100
`define RTVM_CODE_START      24'h000200
`define RTVM_IRQ_LAST        7'h75
`define RTVM_IRQ_SLOTS       128

// ----------------------------------------
// Trap vector numbers
// ----------------------------------------
`define RTVM_TRAP_OSC        3'h1
`define RTVM_TRAP_ADDR       3'h2
`define RTVM_TRAP_STACK      3'h3
`define RTVM_TRAP_MATH       3'h4

`endif

// >>> hw/rtvm_vector_mem.v
// Vector word store: 24-bit handler addresses with registered read
`timescale 1ns/1ps
module rtvm_vector_mem (
	input  wire        sys_clk_in,
	input  wire        wr_en_in,
	input  wire [7:0]  wr_idx_in,
	input  wire [23:0] wr_data_in,
	input  wire [7:0]  rd_idx_in,
	output reg  [23:0] rd_data_out
);
	reg [23:0] mem_q [0:255];

	always @(posedge sys_clk_in) begin
		if (wr_en_in) begin
			mem_q[wr_idx_in] <= wr_data_in;
		end
		rd_data_out <= mem_q[rd_idx_in];
	end
endmodule

// >>> hw/rtvm_mapper.v
// Reset entry, trap and interrupt vector address mapper with fetch
// Notes on behaviour
// - Reset clears state and sets the program counter to address zero.
// - Reset bypasses table lookup and arbitration and is no exception.
// - Eight trap vectors sit two units apart from 04h, or 104h alternate.
// - Oscillator fail is trap 1, address 2, stack 3, math 4; rest reserved.
// - Interrupt vectors 0..117 sit two units apart from 14h up to FEh.
// - The alternate table is the primary layout moved up by 100h.
// - Lower vector numbers win arbitration, traps before interrupts.
// - With alternate select set every vector comes from the alternate table.
// - Each slot holds a 24-bit handler address loaded into the PC.
`timescale 1ns/1ps
`include "rtvm_map.vh"
module rtvm_mapper (
	// ----------------------------------------
	// Clock and reset
	// ----------------------------------------
	input  wire         sys_clk_in,
	input  wire         reset_n_in,
	// ----------------------------------------
	// Vector requests
	// ----------------------------------------
	input  wire         alt_table_select_in,
	input  wire         trap_osc_in,
	input  wire         trap_addr_in,
	input  wire         trap_stack_in,
	input  wire         trap_math_in,
	input  wire [127:0] irq_req_in,
	// ----------------------------------------
	// Vector store writes
	// ----------------------------------------
	input  wire         vec_wr_en_in,
	input  wire [23:0]  vec_wr_addr_in,
	input  wire [23:0]  vec_wr_data_in,
	// ----------------------------------------
	// CPU side
	// ----------------------------------------
	input  wire         cpu_ack_in,
	output reg  [23:0]  pc_out,
	output reg          pc_load_out,
	output reg  [23:0]  fetch_addr_out,
	output reg          is_trap_out,
	output reg  [6:0]   vec_num_out,
	output reg          busy_out
);
	// ----------------------------------------
	// Request arbitration
	// ----------------------------------------
	// Only vectors 0..117 are implemented; upper bits are ignored
	wire [127:0] irq_valid;
	genvar gi;
	generate
		for (gi = 0; gi < `RTVM_IRQ_SLOTS; gi = gi + 1) begin : g_irq
			assign irq_valid[gi] = irq_req_in[gi] &&
				(gi <= `RTVM_IRQ_LAST);
		end
	endgenerate

	reg       any_trap;
	reg [2:0] trap_num;
	reg       any_irq;
	reg [6:0] irq_num;
	integer   i;

	always @* begin
		any_trap = 1'b1;
		trap_num = 3'h0;
		if (trap_osc_in) begin
			trap_num = `RTVM_TRAP_OSC;
		end else if (trap_addr_in) begin
			trap_num = `RTVM_TRAP_ADDR;
		end else if (trap_stack_in) begin
			trap_num = `RTVM_TRAP_STACK;
		end else if (trap_math_in) begin
			trap_num = `RTVM_TRAP_MATH;
		end else begin
			any_trap = 1'b0;
		end
		// Scan downward so the lowest set number is kept
		any_irq = 1'b0;
		irq_num = 7'h00;
		for (i = `RTVM_IRQ_SLOTS - 1; i >= 0; i = i - 1) begin
			if (irq_valid[i]) begin
				any_irq = 1'b1;
				irq_num = i[6:0];
			end
		end
	end

	// ----------------------------------------
	// Vector address formation
	// ----------------------------------------
	reg [23:0] table_base;
	reg [23:0] sel_addr;

	always @* begin
		table_base = any_trap ? `RTVM_TRAP_BASE : `RTVM_IRQ_BASE;
		if (alt_table_select_in) begin
			table_base = table_base + `RTVM_ALT_OFFSET;
		end
		if (any_trap) begin
			sel_addr = table_base + {20'h00000, trap_num, 1'b0};
		end else begin
			sel_addr = table_base + {16'h0000, irq_num, 1'b0};
		end
	end

	// ----------------------------------------
	// Vector store
	// ----------------------------------------
	// Word index is address/2; the tables span 000h..1FFh
	reg  [7:0]  rd_idx_q;
	wire [23:0] vec_word;
	wire        store_wr_en;

	// Writes at or above the code start are dropped
	assign store_wr_en = vec_wr_en_in && (vec_wr_addr_in < `RTVM_CODE_START);

	rtvm_vector_mem u_mem (
		.sys_clk_in  (sys_clk_in),
		.wr_en_in    (store_wr_en),
		.wr_idx_in   (vec_wr_addr_in[8:1]),
		.wr_data_in  (vec_wr_data_in),
		.rd_idx_in   (rd_idx_q),
		.rd_data_out (vec_word)
	);

	// ----------------------------------------
	// Fetch sequencer states
	// ----------------------------------------
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_READ = 2'h1;
	localparam [1:0] ST_LOAD = 2'h2;

	// ----------------------------------------
	// Fetch sequencer next state
	// ----------------------------------------
	reg [1:0]  state_q;
	reg [1:0]  state_d;
	reg [23:0] pc_d;
	reg        pc_load_d;
	reg [23:0] fetch_addr_d;
	reg        is_trap_d;
	reg [6:0]  vec_num_d;
	reg        busy_d;
	reg [7:0]  rd_idx_d;
	wire       any_req;

	// Reset never takes this path; its entry address is forced below
	assign any_req = any_trap || any_irq;

	always @* begin
		state_d      = state_q;
		pc_d         = pc_out;
		pc_load_d    = 1'b0;
		fetch_addr_d = fetch_addr_out;
		is_trap_d    = is_trap_out;
		vec_num_d    = vec_num_out;
		busy_d       = busy_out;
		rd_idx_d     = rd_idx_q;
		case (state_q)
			ST_IDLE: begin
				if (any_req) begin
					fetch_addr_d = sel_addr;
					rd_idx_d     = sel_addr[8:1];
					is_trap_d    = any_trap;
					vec_num_d    = any_trap ? {4'h0, trap_num}
						: irq_num;
					busy_d       = 1'b1;
					state_d      = ST_READ;
				end
			end
			ST_READ: begin
				// Store output is registered; wait one cycle for it
				state_d = ST_LOAD;
			end
			ST_LOAD: begin
				pc_d      = vec_word;
				pc_load_d = 1'b1;
				busy_d    = 1'b0;
				state_d   = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// Fetch sequencer registers
	// ----------------------------------------
	always @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			state_q        <= ST_IDLE;
			pc_out         <= `RTVM_RESET_ADDR;
			pc_load_out    <= 1'b1;
			fetch_addr_out <= 24'h000000;
			is_trap_out    <= 1'b0;
			vec_num_out    <= 7'h00;
			busy_out       <= 1'b0;
			rd_idx_q       <= 8'h00;
		end else begin
			state_q        <= state_d;
			pc_out         <= pc_d;
			pc_load_out    <= pc_load_d;
			fetch_addr_out <= fetch_addr_d;
			is_trap_out    <= is_trap_d;
			vec_num_out    <= vec_num_d;
			busy_out       <= busy_d;
			rd_idx_q       <= rd_idx_d;
		end
	end

	// ----------------------------------------
	// Unused inputs
	// ----------------------------------------
	// Sequencing is fixed, so the acknowledge is not needed
	wire unused_ack;
	assign unused_ack = cpu_ack_in;
endmodule

// >>> sim/rtvm_monitor.sv
// Port checker for the vector mapper
`timescale 1ns/1ps
module rtvm_monitor (
	input logic        sys_clk_in,
	input logic        reset_n_in,
	input logic        alt_table_select_in,
	input logic        trap_osc_in,
	input logic [23:0] pc_out,
	input logic        pc_load_out,
	input logic [23:0] fetch_addr_out,
	input logic        is_trap_out,
	input logic [6:0]  vec_num_out,
	input logic        busy_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);
	a_load_pulse: assert property (pc_load_out |=> !pc_load_out)
		else $error("pc load too long");
	a_fetch_timing: assert property ($rose(busy_out) |->
		##1 busy_out ##1 (!busy_out && pc_load_out)) else $error("fetch late");
	a_trap_slot: assert property ($rose(busy_out) && is_trap_out |->
		fetch_addr_out == 24'h4 + 2 * vec_num_out +
		($past(alt_table_select_in) ? 24'h100 : 24'h0)) else $error("trap slot");
	a_irq_slot: assert property ($rose(busy_out) && !is_trap_out |->
		fetch_addr_out == 24'h14 + 2 * vec_num_out +
		($past(alt_table_select_in) ? 24'h100 : 24'h0)) else $error("irq slot");
	a_trap_range: assert property (is_trap_out |-> vec_num_out inside {[1:4]})
		else $error("trap number");
	a_irq_range: assert property (busy_out && !is_trap_out |-> vec_num_out <= 117)
		else $error("irq number");
	a_trap_first: assert property ($rose(busy_out) && $past(trap_osc_in) |->
		is_trap_out && vec_num_out == 7'h1) else $error("priority");
	a_reset_entry: assert property (disable iff (1'b0) !reset_n_in |=>
		pc_out == 24'h0 && pc_load_out && !busy_out) else $error("reset entry");
	cover property ($rose(busy_out) && is_trap_out);
	cover property ($rose(busy_out) && $past(alt_table_select_in));
	cover property (pc_load_out && !busy_out);
endmodule
bind rtvm_mapper rtvm_monitor i_mon (.*);

// >>> sim/rtvm_cpu_model.sv
// CPU side: loads the program counter on each load pulse
`timescale 1ns/1ps
module rtvm_cpu_model (
	input  logic        sys_clk_in,
	input  logic        pc_load_in,
	input  logic [23:0] pc_in,
	output logic [23:0] pc_q
);
	always @(posedge sys_clk_in) if (pc_load_in) pc_q <= pc_in;
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the vector mapper
`timescale 1ns/1ps
module tb_top;
	logic clk = 0, rst_n = 0, alt = 0, we = 0, ld, it, bsy;
	logic [3:0] trp = 0;
	logic [127:0] irq = 0;
	logic [23:0] wa = 0, wd = 0, pc, fa, cpc;
	logic [6:0] vn;
	int error_cnt = 0, compares = 0, i, n;
	always #25 clk = ~clk;
	rtvm_mapper i_dut (.sys_clk_in(clk), .reset_n_in(rst_n),
		.alt_table_select_in(alt), .trap_osc_in(trp[0]), .trap_addr_in(trp[1]),
		.trap_stack_in(trp[2]), .trap_math_in(trp[3]), .irq_req_in(irq),
		.vec_wr_en_in(we), .vec_wr_addr_in(wa), .vec_wr_data_in(wd),
		.cpu_ack_in(1'b0), .pc_out(pc), .pc_load_out(ld), .fetch_addr_out(fa),
		.is_trap_out(it), .vec_num_out(vn), .busy_out(bsy));
	rtvm_cpu_model i_cpu (.sys_clk_in(clk), .pc_load_in(ld), .pc_in(pc),
		.pc_q(cpc));
	function logic [23:0] hdl(logic [23:0] a);
		return a ^ 24'hC3A500;
	endfunction
	task chk(logic [23:0] g, logic [23:0] e);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task results;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task rst;
		rst_n = 0;
		repeat (4) @(posedge clk);
		#1 chk({pc[23:1], ld}, 24'h1);
		chk(cpc, 24'h0);
		rst_n = 1;
	endtask
	task take(logic [3:0] tm, logic [127:0] im, bit al, bit t, int v);
		logic [23:0] e;
		e = (t ? 24'h4 : 24'h14) + 2 * v + (al ? 24'h100 : 24'h0);
		@(posedge clk);
		#1 trp = tm;
		irq = im;
		alt = al;
		@(posedge clk);
		#1 trp = 0;
		irq = 0;
		n = 0;
		while (!ld && n < 8) begin
			@(posedge clk);
			#1 n++;
		end
		if (n == 8) begin
			error_cnt++;
			results;
		end
		chk(fa, e);
		chk({16'h0, it, vn}, {16'h0, t, v[6:0]});
		chk(pc, hdl(e));
		@(posedge clk);
		#1 chk(cpc, hdl(e));
	endtask
	initial begin
		n = $urandom(32'hEA73);
		rst;
		for (i = 0; i < 256; i++) begin
			we = 1;
			wa = 2 * i;
			wd = hdl(2 * i);
			@(posedge clk);
			#1 we = 0;
		end
		for (i = 0; i < 8; i++) take(4'h1 << i[1:0], 0, i[2], 1, i[1:0] + 1);
		take(4'hC, 128'h1, 1, 1, 3);
		take(0, ~128'h0 << 117, 0, 0, 117);
		take(0, 128'h3 << 116, 1, 0, 116);
		take(0, 128'h1, 1, 0, 0);
		repeat (20) begin
			i = $urandom_range(117, 0);
			take(0, 128'h1 << i | 128'h1 << 117, $urandom, 0, i);
		end
		rst;
		take(4'h8, 128'h5, 0, 1, 4);
		results;
	end
endmodule
